// ==== rtl/uiom_pkg.sv ====
// Constants and types for the upstream IO-or-memory window base register.
// Assumes a 32-bit APB slave port and setup/translated-base values from other core logic.
package uiom_pkg;
    localparam int UIOM_PADDR_W = 12;
    localparam logic [UIOM_PADDR_W-1:0] UIOM_BAR_OFS = 12'h058;
    localparam int UIOM_SPACE_BIT = 0;
    localparam int UIOM_TYPE_LSB = 1;
    localparam int UIOM_PREF_BIT = 3;
    localparam int UIOM_BASE_LSB = 6;
    localparam int UIOM_ADDR_MSB = 31;
    localparam int UIOM_BASE_W = UIOM_ADDR_MSB - UIOM_BASE_LSB + 1;
    localparam int UIOM_SETUP_EN_BIT = 31;
    localparam int UIOM_MEM_MIN_LSB = 12;
    localparam int UIOM_IO_MAX_LSB = 8;
    localparam logic [1:0] UIOM_TYPE_32 = 2'h0;
    localparam logic [1:0] UIOM_TYPE_64 = 2'h1;
    localparam logic [1:0] UIOM_RSVD_PAIR = 2'h0;
    localparam logic [UIOM_BASE_W-1:0] UIOM_BASE_RESET = 26'h0000000;
    localparam logic [31:0] UIOM_WORD_ZERO = 32'h00000000;
    typedef enum {UIOM_APB_IDLE, UIOM_APB_DONE} uiom_apb_state_t;
endpackage

// ==== rtl/uiom_apb_slave.sv ====
// APB slave handshake for the single window base register.
// Assumes the master holds its request until pready is seen high.
`timescale 1ns/10ps
module uiom_apb_slave (
    input wire logic clk_in, // Core clock
    input wire logic arst_n_in, // Async reset, active low
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [uiom_pkg::UIOM_PADDR_W-1:0] paddr_in, // APB byte address
    input wire logic [31:0] rd_word_in, // Current register image
    output logic [31:0] prdata_out, // Registered read data
    output logic pready_out, // Registered ready
    output logic pslverr_out, // Registered error
    output logic wr_take_out // Write to the register commits this edge
);
    import uiom_pkg::*;
    uiom_apb_state_t state;
    uiom_apb_state_t next_state;
    wire logic access_w = psel_in && penable_in;
    wire logic mapped_w = (paddr_in == UIOM_BAR_OFS);
    wire logic [31:0] next_prdata = (mapped_w && !pwrite_in) ? rd_word_in : UIOM_WORD_ZERO;

    // One wait state gives a registered answer without a combinational path to pready
    always_comb begin
        next_state = UIOM_APB_IDLE;
        unique case (state)
            UIOM_APB_IDLE: next_state = access_w ? UIOM_APB_DONE : UIOM_APB_IDLE;
            UIOM_APB_DONE: next_state = UIOM_APB_IDLE;
        endcase
    end

    assign wr_take_out = access_w && pready_out && pwrite_in && mapped_w;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= UIOM_APB_IDLE;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= UIOM_WORD_ZERO;
        end else begin
            state <= next_state;
            pready_out <= (state == UIOM_APB_IDLE) && access_w;
            pslverr_out <= (state == UIOM_APB_IDLE) && access_w && !mapped_w;
            prdata_out <= next_prdata;
        end
    end
endmodule

// ==== rtl/uiom_decode.sv ====
// Upstream hit decode and direct address translation for one window.
// Assumes base and mask are already cut to the writable field.
`timescale 1ns/10ps
module uiom_decode (
    input wire logic clk_in, // Core clock
    input wire logic arst_n_in, // Async reset, active low
    input wire logic req_valid_in, // Request strobe
    input wire logic [31:0] req_addr_in, // Secondary-side address
    input wire logic req_io_in, // Request is IO space
    input wire logic win_en_in, // Window may claim
    input wire logic win_io_in, // Window lies in IO space
    input wire logic [uiom_pkg::UIOM_BASE_W-1:0] base_in, // Effective base
    input wire logic [uiom_pkg::UIOM_BASE_W-1:0] mask_in, // Decoded bits
    input wire logic [31:0] xlat_base_in, // Translated base
    output logic hit_out, // Registered hit pulse
    output logic [31:0] fwd_addr_out // Registered forwarded address
);
    import uiom_pkg::*;
    wire logic [UIOM_BASE_W-1:0] req_hi = req_addr_in[UIOM_ADDR_MSB:UIOM_BASE_LSB];
    wire logic [UIOM_BASE_W-1:0] xlat_hi = xlat_base_in[UIOM_ADDR_MSB:UIOM_BASE_LSB];
    wire logic match_w = ((req_hi ^ base_in) & mask_in) == UIOM_BASE_RESET;
    wire logic next_hit = req_valid_in && win_en_in && (req_io_in == win_io_in) && match_w;
    // Decoded bits come from the translated base, the offset inside the window passes through
    wire logic [UIOM_BASE_W-1:0] fwd_hi = (xlat_hi & mask_in) | (req_hi & ~mask_in);
    wire logic [31:0] next_fwd = {fwd_hi, req_addr_in[UIOM_BASE_LSB-1:0]};

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hit_out <= 1'b0;
            fwd_addr_out <= UIOM_WORD_ZERO;
        end else begin
            hit_out <= next_hit;
            fwd_addr_out <= next_hit ? next_fwd : fwd_addr_out;
        end
    end
endmodule

// ==== rtl/uiom_window_bar.sv ====
// Upstream IO-or-memory window base register with its upstream decoder.
// Assumes setup and translated-base words come from core logic on the same clock.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
module uiom_window_bar (
    input wire logic clk_in, // Core clock, 20 MHz
    input wire logic arst_n_in, // Async reset, active low
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction, high writes
    input wire logic [uiom_pkg::UIOM_PADDR_W-1:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    input wire logic [3:0] pstrb_in, // APB byte lane strobes
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error on unmapped address
    input wire logic [31:0] setup_in, // Companion setup register value
    input wire logic [31:0] xlat_base_in, // Companion translated-base value
    input wire logic req_valid_in, // Upstream request strobe
    input wire logic [31:0] req_addr_in, // Upstream request address
    input wire logic req_io_in, // Upstream request is IO space
    output logic hit_out, // Request one cycle back hit the window
    output logic [31:0] fwd_addr_out, // Translated upstream address
    output logic win_en_out // Window was able to claim one cycle back
);
    import uiom_pkg::*;

    logic [UIOM_BASE_W-1:0] base_q;
    logic [UIOM_BASE_W-1:0] next_base;
    logic [UIOM_BASE_W-1:0] wr_mask;
    logic [UIOM_BASE_W-1:0] lane_en;
    logic [31:0] rd_word;
    logic wr_take;

    wire logic win_io = setup_in[UIOM_SPACE_BIT];
    wire logic [1:0] setup_type = setup_in[UIOM_TYPE_LSB+1:UIOM_TYPE_LSB];

    // Reserved setup codes are never shown; software sees a plain 32-bit decoder then
    wire logic [1:0] type_rpt = (setup_type == UIOM_TYPE_64) ? UIOM_TYPE_64 : UIOM_TYPE_32;
    // An IO window is never prefetchable
    wire logic pref_rpt = setup_in[UIOM_PREF_BIT] && !win_io;

    // Writable-bit mask per base bit, from the setup register and the size limits
    genvar gi;
    generate
        for (gi = 0; gi < UIOM_BASE_W; gi++) begin : g_bit
            localparam int ABIT = gi + UIOM_BASE_LSB;
            // Top bit is always decoded: setup bit 31 is the enable, and 2GB is the largest window
            wire logic top_w = (ABIT == UIOM_ADDR_MSB);
            // IO windows stop at 256B, so every bit above it always decodes
            wire logic io_w = (ABIT >= UIOM_IO_MAX_LSB) || setup_in[ABIT];
            // Memory windows start at 4KB, so low bits never become writable
            wire logic mem_w = (ABIT >= UIOM_MEM_MIN_LSB) && setup_in[ABIT];
            assign wr_mask[gi] = top_w || (win_io ? io_w : mem_w);
            assign lane_en[gi] = pstrb_in[ABIT/8];
        end
    endgenerate

    // Bits that are not writable read as zero; base_q keeps them, so a shrunk window shows their old stored values again
    wire logic [UIOM_BASE_W-1:0] base_eff = base_q & wr_mask;
    wire logic [UIOM_BASE_W-1:0] wr_bits = wr_mask & lane_en;
    wire logic [UIOM_BASE_W-1:0] wdata_hi = pwdata_in[UIOM_ADDR_MSB:UIOM_BASE_LSB];
    wire logic setup_on = setup_in[UIOM_SETUP_EN_BIT];
    wire logic base_nonzero = (base_eff != UIOM_BASE_RESET);
    wire logic win_en = setup_on && base_nonzero;

    assign next_base = wr_take ? ((base_q & ~wr_bits) | (wdata_hi & wr_bits)) : base_q;
    assign rd_word = {base_eff, UIOM_RSVD_PAIR, pref_rpt, type_rpt, win_io};

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            base_q <= UIOM_BASE_RESET;
            win_en_out <= 1'b0;
        end else begin
            base_q <= next_base;
            win_en_out <= win_en;
        end
    end

    uiom_apb_slave u_apb (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .rd_word_in(rd_word),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .wr_take_out(wr_take)
    );

    uiom_decode u_dec (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .req_valid_in(req_valid_in),
        .req_addr_in(req_addr_in),
        .req_io_in(req_io_in),
        .win_en_in(win_en),
        .win_io_in(win_io),
        .base_in(base_eff),
        .mask_in(wr_mask),
        .xlat_base_in(xlat_base_in),
        .hit_out(hit_out),
        .fwd_addr_out(fwd_addr_out)
    );

    // Helper terms read only by the checks below
    wire logic [UIOM_BASE_W-1:0] req_hi = req_addr_in[UIOM_ADDR_MSB:UIOM_BASE_LSB];
    wire logic [UIOM_BASE_W-1:0] xlat_hi = xlat_base_in[UIOM_ADDR_MSB:UIOM_BASE_LSB];
    wire logic chk_match = ((req_hi ^ base_eff) & wr_mask) == UIOM_BASE_RESET;
    wire logic [UIOM_BASE_W-1:0] chk_fwd_hi = (xlat_hi & wr_mask) | (req_hi & ~wr_mask);
    wire logic apb_done = psel_in && penable_in && pready_out;
    wire logic mem_low_set = !win_io && (wr_mask[UIOM_MEM_MIN_LSB-UIOM_BASE_LSB-1:0] != 6'h00);
    wire logic io_high_clr = win_io && (wr_mask[UIOM_BASE_W-1:UIOM_IO_MAX_LSB-UIOM_BASE_LSB]
        != 24'hffffff);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_setup;
        psel_in && !penable_in;
    endsequence

    sequence s_answer;
        !pready_out ##1 pready_out;
    endsequence

    sequence s_full_write;
        apb_done && pwrite_in && (paddr_in == UIOM_BAR_OFS) && (pstrb_in == 4'hf);
    endsequence

    chk_apb_wait_state: assert property (s_setup |=> s_answer)
        else $error("APB answer not two cycles after setup");

    chk_unmapped_error: assert property (apb_done |-> (pslverr_out == (paddr_in != UIOM_BAR_OFS)))
        else $error("APB error flag disagrees with address decode");

    chk_read_image: assert property (s_setup ##1 (!pwrite_in && paddr_in == UIOM_BAR_OFS
        && $stable(setup_in) && $stable(base_q)) |=> (prdata_out == $past(rd_word)))
        else $error("Read data differs from register image");

    chk_fixed_fields: assert property (apb_done && !pslverr_out && !pwrite_in |->
        (prdata_out[5:4] == UIOM_RSVD_PAIR) && !prdata_out[UIOM_TYPE_LSB+1]
        && !(prdata_out[UIOM_PREF_BIT] && prdata_out[UIOM_SPACE_BIT]))
        else $error("Reserved or read-only field reads wrong");

    chk_write_masked: assert property (s_full_write |=>
        ((base_q & $past(wr_mask)) == ($past(wdata_hi) & $past(wr_mask))))
        else $error("Writable base bits did not take write data");

    chk_ro_bits_kept: assert property (wr_take |=>
        ((base_q & ~$past(wr_mask)) == ($past(base_q) & ~$past(wr_mask))))
        else $error("Read-only base bits changed on write");

    chk_idle_base_stable: assert property (!wr_take |=> $stable(base_q))
        else $error("Base changed without a write");

    chk_size_limits: assert property (!mem_low_set && !io_high_clr && wr_mask[UIOM_BASE_W-1])
        else $error("Window size outside its space limits");

    chk_disabled_no_hit: assert property (req_valid_in && !(setup_on && base_nonzero) |=> !hit_out)
        else $error("Disabled window claimed a request");

    sequence s_request_taken;
        req_valid_in && win_en && (req_io_in == win_io) && chk_match;
    endsequence

    chk_hit_claimed: assert property (s_request_taken |=> hit_out)
        else $error("Matching request not claimed");

    chk_translation: assert property (req_valid_in && win_en && (req_io_in == win_io) && chk_match
        |=> (fwd_addr_out == {$past(chk_fwd_hi), $past(req_addr_in[UIOM_BASE_LSB-1:0])}))
        else $error("Forwarded address not translated");

    chk_status_follow: assert property (win_en_out == $past(win_en) || $fell(arst_n_in))
        else $error("Window status output lags enable");

    // Read answers that carry the register image rather than an error
    sequence s_read_done;
        apb_done && !pwrite_in && !pslverr_out;
    endsequence

    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("APB ready held longer than one cycle");

    chk_error_reads_zero: assert property (apb_done && pslverr_out |->
        (prdata_out == UIOM_WORD_ZERO))
        else $error("Refused access returned nonzero read data");

    // The image was taken one edge before the answer, so the space is looked at there too
    chk_mem_low_read: assert property (s_read_done ##0 !$past(win_io) |->
        (prdata_out[UIOM_MEM_MIN_LSB-1:UIOM_BASE_LSB] == 6'h00))
        else $error("Memory window shows base bits below its minimum size");

    chk_io_read_flags: assert property (s_read_done ##0 $past(win_io) |->
        (prdata_out[UIOM_SPACE_BIT] && !prdata_out[UIOM_PREF_BIT]))
        else $error("IO window reads wrong space or prefetch flag");

    chk_type_code: assert property (s_read_done ##0
        ($past(setup_type) != UIOM_TYPE_64) |->
        (prdata_out[UIOM_TYPE_LSB+1:UIOM_TYPE_LSB] == UIOM_TYPE_32))
        else $error("Address type other than 64-bit does not read as 32-bit");

    chk_space_mismatch: assert property (req_valid_in && (req_io_in != win_io) |=> !hit_out)
        else $error("Request of the other space claimed");

    chk_hit_needs_req: assert property (hit_out |-> $past(req_valid_in))
        else $error("Hit without a request one cycle earlier");

    chk_fwd_holds: assert property (!hit_out |-> $stable(fwd_addr_out))
        else $error("Forwarded address moved without a hit");

    chk_enable_gate: assert property (!setup_on |=> !win_en_out)
        else $error("Window status high with setup enable clear");
endmodule

// ==== verification/uiom_up_master.sv ====
// Secondary-side master model that issues one-cycle upstream requests.
// Assumes the bench pulses go_in for one cycle and then waits for req_valid_out.
`timescale 1ns/10ps
module uiom_up_master (
    input wire logic clk_in, // Core clock
    input wire logic arst_n_in, // Async reset, active low
    input wire logic go_in, // Start one request
    input wire logic [31:0] addr_in, // Address to issue
    input wire logic io_in, // Request is IO space
    input wire logic [3:0] wait_in, // Idle cycles before the strobe
    output logic req_valid_out, // Request strobe
    output logic [31:0] req_addr_out, // Request address
    output logic req_io_out // Request space
);
    logic [4:0] cnt;
    logic fire;
    assign fire = (cnt == 5'h01);
    // Released lines flip each cycle so a stale address can never pass for a request
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= 5'h00;
            req_valid_out <= 1'b0;
            req_addr_out <= 32'h0;
            req_io_out <= 1'b0;
        end else begin
            req_valid_out <= fire;
            req_addr_out <= fire ? addr_in : ~req_addr_out;
            req_io_out <= fire ? io_in : ~req_io_out;
            if (go_in) begin
                cnt <= {1'b0, wait_in} + 5'h01;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the window base register and its upstream decode.
// Assumes the master model in uiom_up_master.sv drives the upstream request side.
`timescale 1ns/10ps
module tb_top;
    import uiom_pkg::*;
    logic clk_in = 1'b0, arst_n_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [UIOM_PADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, setup = 32'h0, xlat = 32'h0, addr = 32'h0;
    logic [31:0] prdata, fwd, req_addr;
    logic [3:0] pstrb = 4'h0, dly = 4'h0;
    logic pready, pslverr, go = 1'b0, io = 1'b0, req_valid, req_io, hit, win_en;
    int err_total = 0, check_count = 0, cycles = 0;
    uiom_window_bar uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .setup_in(setup), .xlat_base_in(xlat), .req_valid_in(req_valid),
        .req_addr_in(req_addr), .req_io_in(req_io), .hit_out(hit), .fwd_addr_out(fwd),
        .win_en_out(win_en));
    uiom_up_master up_mst (.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go),
        .addr_in(addr), .io_in(io), .wait_in(dly), .req_valid_out(req_valid),
        .req_addr_out(req_addr), .req_io_out(req_io));
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run is under two hundred cycles; the ceiling leaves a wide margin
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] exp_rd, input logic exp_err);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        check(prdata, exp_rd);
        check({31'h0, pslverr}, {31'h0, exp_err});
    endtask
    task automatic wr(input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, 12'h058, d, s, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [31:0] exp);
        apb(1'b0, 12'h058, 32'h0, 4'h0, exp, 1'b0);
    endtask
    task automatic cfg(input logic [31:0] s, input logic [31:0] x);
        @(posedge clk_in);
        setup <= s;
        xlat <= x;
    endtask
    task automatic up(input logic [31:0] a, input logic i, input logic [3:0] w,
                      input logic exp_hit, input logic [31:0] exp_fwd);
        @(posedge clk_in);
        go <= 1'b1;
        addr <= a;
        io <= i;
        dly <= w;
        @(posedge clk_in);
        go <= 1'b0;
        while (req_valid !== 1'b1) @(posedge clk_in);
        #1;
        check({31'h0, hit}, {31'h0, exp_hit});
        check(fwd, exp_fwd);
    endtask
    task automatic t_reset();
        rd(32'h0);
        check({31'h0, win_en}, 32'h0);
    endtask
    task automatic t_mem();
        cfg(32'hfffff00a, 32'habcde000);
        wr(32'hffffffff, 4'hf);
        rd(32'hfffff00a);
        wr(32'h12345000, 4'hf);
        rd(32'h1234500a);
        check({31'h0, win_en}, 32'h1);
        up(32'h12345abc, 1'b0, 4'h0, 1'b1, 32'habcdeabc);
        up(32'h12346000, 1'b0, 4'h3, 1'b0, 32'habcdeabc);
        up(32'h12345abc, 1'b1, 4'h1, 1'b0, 32'habcdeabc);
    endtask
    task automatic t_wide();
        cfg(32'h80000000, 32'h2bcde000);
        rd(32'h0);
        check({31'h0, win_en}, 32'h0);
        up(32'h12345abc, 1'b0, 4'h0, 1'b0, 32'habcdeabc);
        wr(32'h80000000, 4'hf);
        rd(32'h80000000);
        up(32'h90000040, 1'b0, 4'h2, 1'b1, 32'h10000040);
    endtask
    task automatic t_off();
        cfg(32'h7ffff00a, 32'h2bcde000);
        up(32'h90000040, 1'b0, 4'h0, 1'b0, 32'h10000040);
        check({31'h0, win_en}, 32'h0);
    endtask
    task automatic t_io();
        cfg(32'hffffff09, 32'h2bcde000);
        wr(32'hffffffff, 4'hf);
        rd(32'hffffff01);
        cfg(32'hffffffc1, 32'h2bcde000);
        wr(32'h00001240, 4'hf);
        rd(32'h00001241);
        wr(32'hffffffff, 4'h1);
        rd(32'h000012c1);
        up(32'h000012c3, 1'b1, 4'h0, 1'b1, 32'h2bcde003);
        up(32'h00001283, 1'b1, 4'h0, 1'b0, 32'h2bcde003);
        up(32'h000012c3, 1'b0, 4'h0, 1'b0, 32'h2bcde003);
    endtask
    task automatic t_err();
        apb(1'b0, 12'h05c, 32'h0, 4'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h05c, 32'h0, 4'hf, 32'h0, 1'b1);
        cfg(32'hffffffc5, 32'h2bcde000);
        rd(32'h000012c1);
    endtask
    task automatic t_rerun();
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd(32'h00000001);
        check({31'h0, win_en}, 32'h0);
        check(fwd, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        t_reset();
        t_mem();
        t_wide();
        t_off();
        t_io();
        t_err();
        t_rerun();
        complete_run();
    end
endmodule
